// ==== core/tsq_defs.svh ====
// Purpose: Constants for the eight-term trace sequencer.
// Assumes: Byte addresses on a 32-bit AHB-Lite register bus.
// Notes: Offsets and field positions are used by the core and by the bench.
`ifndef TSQ_DEFS_SVH
`define TSQ_DEFS_SVH

`define TSQ_NUM_TERMS 8
`define TSQ_EXPR_W 8
`define TSQ_CNT_W 16

`define TSQ_OFF_CTRL 12'h000
`define TSQ_OFF_STATUS 12'h004
`define TSQ_OFF_SEL 12'h008
`define TSQ_OFF_PRIM 12'h00C
`define TSQ_OFF_SEC 12'h010
`define TSQ_OFF_STORE 12'h014
`define TSQ_OFF_TRIG 12'h018
`define TSQ_OFF_SIMPLE 12'h01C
`define TSQ_OFF_STATE 12'h020

`define TSQ_CTRL_COMPLEX 0
`define TSQ_CTRL_START 1
`define TSQ_CTRL_STOP 2

`define TSQ_EXPR_ANY 8'hFF
`define TSQ_EXPR_NEVER 8'h00
`define TSQ_TRIG_DEFAULT 3'h1
`define TSQ_CNT_ONE 16'h0001

`endif

// ==== core/tsq_pkg.sv ====
// Purpose: Types shared by the trace sequencer and its bench.
// Assumes: Constants come from tsq_defs.svh.
// Notes: A branch expression is an OR over the pattern match bits that it selects.
`include "tsq_defs.svh"
`default_nettype none
package tsq_pkg;
  typedef struct packed {
    logic [`TSQ_EXPR_W-1:0] prim_expr;
    logic [`TSQ_CNT_W-1:0] prim_count;
    logic [2:0] prim_dest;
    logic [`TSQ_EXPR_W-1:0] sec_expr;
    logic [2:0] sec_dest;
    logic [`TSQ_EXPR_W-1:0] store_expr;
  } tsq_term_t;

  typedef struct packed {
    logic valid;
    logic [`TSQ_EXPR_W-1:0] match;
  } tsq_sample_t;

  typedef enum logic [1:0] {
    TSQ_IDLE,
    TSQ_RUN
  } tsq_run_t;
endpackage
`default_nettype wire

// ==== core/tsq_core.sv ====
// Purpose: Eight-term trace sequencer with AHB-Lite register access.
// Assumes: Pattern match bits arrive synchronous to clk, one state per valid.
// Notes: Pattern recognizers and trace memory live outside this block.
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`include "tsq_defs.svh"
`default_nettype none
module tsq_core #(
  parameter int NUM_TERMS = `TSQ_NUM_TERMS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire tsq_pkg::tsq_sample_t sample,
  output logic store_r,
  output logic trigger_r,
  output logic easy_clear_r
);
  initial begin
    if (NUM_TERMS != 8) begin
      $error("tsq_core serves exactly eight terms");
    end
  end

  tsq_pkg::tsq_term_t terms_r [NUM_TERMS];
  logic complex_r;
  tsq_pkg::tsq_run_t run_r;
  logic [2:0] sel_r;
  logic [2:0] trig_term_r;
  logic [2:0] cur_r;
  logic [`TSQ_CNT_W-1:0] cnt_r;
  logic triggered_r;
  logic ap_wr_r;
  logic ap_rd_r;
  logic [11:0] ap_addr_r;

  function automatic logic hit(input logic [`TSQ_EXPR_W-1:0] expr,
                               input logic [`TSQ_EXPR_W-1:0] m);
    hit = |(expr & m);
  endfunction

  function automatic tsq_pkg::tsq_term_t dflt_term(input int idx);
    tsq_pkg::tsq_term_t t;
    t.prim_expr = (idx == NUM_TERMS - 1) ? `TSQ_EXPR_NEVER : `TSQ_EXPR_ANY;
    t.prim_count = `TSQ_CNT_ONE;
    t.prim_dest = (idx == NUM_TERMS - 1) ? 3'(idx) : 3'(idx + 1);
    t.sec_expr = `TSQ_EXPR_NEVER;
    t.sec_dest = 3'h0;
    t.store_expr = `TSQ_EXPR_ANY;
    dflt_term = t;
  endfunction

  // Bus address phase is captured; the write data follows one cycle later.
  wire logic ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_addr_r <= 12'h000;
    end else begin
      ap_wr_r <= ap_valid && hwrite;
      ap_rd_r <= ap_valid && !hwrite;
      ap_addr_r <= haddr;
    end
  end

  wire logic wr_ctrl = ap_wr_r && ap_addr_r == `TSQ_OFF_CTRL;
  wire logic go_complex = wr_ctrl && hwdata[`TSQ_CTRL_COMPLEX] && !complex_r;
  wire logic go_easy = wr_ctrl && !hwdata[`TSQ_CTRL_COMPLEX] && complex_r;
  wire logic start_req = wr_ctrl && hwdata[`TSQ_CTRL_START];
  wire logic stop_req = wr_ctrl && hwdata[`TSQ_CTRL_STOP];
  wire logic wr_simple = ap_wr_r && ap_addr_r == `TSQ_OFF_SIMPLE;

  // Sequencer evaluation of the current state.
  tsq_pkg::tsq_term_t ct;
  logic p_hit;
  logic s_hit;
  logic p_take;
  logic s_take;
  logic [2:0] dest;
  always_comb begin
    ct = terms_r[cur_r];
    p_hit = sample.valid && hit(ct.prim_expr, sample.match);
    s_hit = sample.valid && hit(ct.sec_expr, sample.match);
    p_take = p_hit && cnt_r <= `TSQ_CNT_ONE;
    s_take = s_hit && !p_hit;
    dest = p_take ? ct.prim_dest : ct.sec_dest;
  end
  wire logic branch = run_r == tsq_pkg::TSQ_RUN && (p_take || s_take);
  wire logic running = run_r == tsq_pkg::TSQ_RUN;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      complex_r <= 1'b0;
      trig_term_r <= `TSQ_TRIG_DEFAULT;
      sel_r <= 3'h0;
      for (int i = 0; i < NUM_TERMS; i++) begin
        terms_r[i] <= dflt_term(i);
      end
    end else begin
      if (wr_ctrl) begin
        complex_r <= hwdata[`TSQ_CTRL_COMPLEX];
      end
      if (go_complex) begin
        for (int i = 0; i < NUM_TERMS; i++) begin
          terms_r[i] <= dflt_term(i);
        end
        trig_term_r <= `TSQ_TRIG_DEFAULT;
      end else if (wr_simple) begin
        terms_r[0].prim_expr <= hwdata[`TSQ_EXPR_W-1:0];
        terms_r[0].sec_expr <= `TSQ_EXPR_NEVER;
        terms_r[1].prim_expr <= `TSQ_EXPR_NEVER;
        terms_r[1].sec_expr <= `TSQ_EXPR_NEVER;
        trig_term_r <= `TSQ_TRIG_DEFAULT;
      end else if (ap_wr_r) begin
        unique case (ap_addr_r)
          `TSQ_OFF_SEL: sel_r <= hwdata[2:0];
          `TSQ_OFF_PRIM: begin
            terms_r[sel_r].prim_expr <= hwdata[7:0];
            terms_r[sel_r].prim_dest <= hwdata[10:8];
            terms_r[sel_r].prim_count <= hwdata[31:16];
          end
          `TSQ_OFF_SEC: begin
            terms_r[sel_r].sec_expr <= hwdata[7:0];
            terms_r[sel_r].sec_dest <= hwdata[10:8];
          end
          `TSQ_OFF_STORE: terms_r[sel_r].store_expr <= hwdata[7:0];
          `TSQ_OFF_TRIG: begin
            if (hwdata[2:0] != 3'h0) begin
              trig_term_r <= hwdata[2:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Leaving complex mode asks the easy-mode logic outside to clear its settings.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      easy_clear_r <= 1'b0;
    end else begin
      easy_clear_r <= go_easy;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= tsq_pkg::TSQ_IDLE;
      cur_r <= 3'h0;
      cnt_r <= `TSQ_CNT_ONE;
      triggered_r <= 1'b0;
    end else if (start_req || go_complex) begin
      run_r <= start_req ? tsq_pkg::TSQ_RUN : tsq_pkg::TSQ_IDLE;
      cur_r <= 3'h0;
      cnt_r <= go_complex ? `TSQ_CNT_ONE : terms_r[0].prim_count;
      triggered_r <= 1'b0;
    end else if (stop_req) begin
      run_r <= tsq_pkg::TSQ_IDLE;
    end else if (branch) begin
      cur_r <= dest;
      cnt_r <= terms_r[dest].prim_count;
      if (dest == trig_term_r) begin
        triggered_r <= 1'b1;
      end
    end else if (running && p_hit) begin
      cnt_r <= cnt_r - `TSQ_CNT_ONE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigger_r <= 1'b0;
      store_r <= 1'b0;
    end else begin
      trigger_r <= branch && dest == trig_term_r && !triggered_r;
      store_r <= running && sample.valid &&
        (branch || hit(ct.store_expr, sample.match));
    end
  end

  // Registers answer with zero wait states; the status word shows live state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      unique case (haddr)
        `TSQ_OFF_CTRL: hrdata <= {31'h00000000, complex_r};
        `TSQ_OFF_STATUS: hrdata <= {28'h0000000, triggered_r,
                                    run_r == tsq_pkg::TSQ_RUN, 2'h0};
        `TSQ_OFF_SEL: hrdata <= {29'h00000000, sel_r};
        `TSQ_OFF_PRIM: hrdata <= {terms_r[sel_r].prim_count, 5'h00,
                                  terms_r[sel_r].prim_dest, terms_r[sel_r].prim_expr};
        `TSQ_OFF_SEC: hrdata <= {21'h000000, terms_r[sel_r].sec_dest,
                                 terms_r[sel_r].sec_expr};
        `TSQ_OFF_STORE: hrdata <= {24'h000000, terms_r[sel_r].store_expr};
        `TSQ_OFF_TRIG: hrdata <= {29'h00000000, trig_term_r};
        `TSQ_OFF_SIMPLE: hrdata <= {24'h000000, terms_r[0].prim_expr};
        `TSQ_OFF_STATE: hrdata <= {cnt_r, 13'h0000, cur_r};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  wire logic unused_ok = ap_rd_r ^ (|hsize);
endmodule
`default_nettype wire

// ==== tb/tsq_core_sva.sv ====
// Purpose: Port-level checks for the trace sequencer.
// Assumes: Bound into tsq_core; single clock domain.
// Notes: Store and trigger pulses are judged against the sample one cycle earlier, clear pulses against the control write two cycles earlier.
`include "tsq_defs.svh"
`default_nettype none
module tsq_core_chk #(
  parameter int NUM_TERMS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire tsq_pkg::tsq_sample_t sample,
  input wire logic store_r,
  input wire logic trigger_r,
  input wire logic easy_clear_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic ctrl_wr;
  assign ctrl_wr = hsel && htrans[1] && hwrite && haddr == `TSQ_OFF_CTRL;
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_trig_stored: assert property (trigger_r |-> store_r) else $error("branch not stored");
  a_trig_cause: assert property (trigger_r |-> $past(sample.valid))
    else $error("trigger without state");
  a_store_cause: assert property (store_r |-> $past(sample.valid))
    else $error("store without state");
  a_trig_once: assert property (trigger_r |=> !trigger_r [*2])
    else $error("trigger repeated");
  a_clear_cause: assert property (easy_clear_r |-> $past(ctrl_wr, 2))
    else $error("clear without mode write");
  a_clear_once: assert property (easy_clear_r |=> !easy_clear_r) else $error("long clear");
endmodule

bind tsq_core tsq_core_chk #(.NUM_TERMS(NUM_TERMS)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hresp(hresp), .sample(sample), .store_r(store_r), .trigger_r(trigger_r),
  .easy_clear_r(easy_clear_r));
`default_nettype wire

// ==== tb/tsq_state_src.sv ====
// Purpose: Source of captured bus states for the sequencer.
// Assumes: One state per call, valid for one cycle.
// Notes: Idle match bits carry the inverse so stale values never pass.
`default_nettype none
module tsq_state_src (
  input wire logic clk,
  output var tsq_pkg::tsq_sample_t sample
);
  initial sample = '0;
  task automatic put(input logic [7:0] m, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    sample <= {1'b1, m};
    @(posedge clk);
    sample <= {1'b0, ~m};
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the trace sequencer.
// Assumes: Zero-wait AHB-Lite slave; state source model.
// Notes: Table rows are {write, address, data or expected}.
`include "tsq_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, q;
  logic hreadyout, hresp, store_r, trigger_r, easy_clear_r;
  tsq_pkg::tsq_sample_t sample;
  int num_errors = 0, compares = 0;
  logic [44:0] rows[23] = '{{1'b0, 12'h018, 32'h1},
    {1'b1, 12'h008, 32'h7}, {1'b0, 12'h00C, 32'h10700},
    {1'b1, 12'h008, 32'h0}, {1'b0, 12'h00C, 32'h101FF},
    {1'b0, 12'h010, 32'h0}, {1'b0, 12'h014, 32'hFF},
    {1'b1, 12'h010, 32'h305}, {1'b1, 12'h018, 32'h3}, {1'b1, 12'h01C, 32'h4},
    {1'b0, 12'h01C, 32'h4}, {1'b0, 12'h00C, 32'h10104},
    {1'b0, 12'h010, 32'h300}, {1'b0, 12'h018, 32'h1},
    {1'b1, 12'h008, 32'h1}, {1'b0, 12'h00C, 32'h10200},
    {1'b1, 12'h018, 32'h0}, {1'b0, 12'h018, 32'h1},
    {1'b1, 12'h000, 32'h1}, {1'b1, 12'h008, 32'h0}, {1'b0, 12'h00C, 32'h101FF},
    {1'b0, 12'h0FC, 32'h0}, {1'b1, 12'h000, 32'h0}};
  always #12.5 clk = ~clk;
  tsq_core dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample(sample), .store_r(store_r),
    .trigger_r(trigger_r), .easy_clear_r(easy_clear_r));
  tsq_state_src src (.clk(clk), .sample(sample));
  task automatic stop_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // Sampling at the falling edge gives the value the next rising edge sees, without a race.
  task automatic wait_rdy();
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge clk);
      r = hreadyout;
      q = hrdata;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i][44], rows[i][43:32], rows[i][31:0]);
      if (!rows[i][44]) chk(q, rows[i][31:0]);
    end
    @(negedge clk);
    chk1(easy_clear_r, 1'b1);
    bus(1'b1, 12'h000, 32'h1);
    src.put(8'h01, 0);
    chk1(store_r, 1'b0);
    bus(1'b1, 12'h008, 32'h0);
    bus(1'b1, 12'h00C, 32'h20301);
    bus(1'b1, 12'h010, 32'h502);
    bus(1'b1, 12'h014, 32'h0);
    bus(1'b1, 12'h018, 32'h5);
    bus(1'b1, 12'h008, 32'h3);
    bus(1'b1, 12'h00C, 32'h10504);
    bus(1'b1, 12'h000, 32'h3);
    src.put(8'h01, 0);
    chk1(store_r, 1'b0);
    bus(1'b0, 12'h020, 32'h0);
    chk(q, 32'h10000);
    src.put(8'h03, 2);
    chk1(store_r, 1'b1);
    bus(1'b0, 12'h020, 32'h0);
    chk(q, 32'h10003);
    src.put(8'h04, 0);
    chk1(trigger_r, 1'b1);
    bus(1'b0, 12'h004, 32'h0);
    chk(q, 32'hC);
    bus(1'b1, 12'h000, 32'h3);
    src.put(8'h02, 1);
    chk1(trigger_r, 1'b1);
    bus(1'b0, 12'h020, 32'h0);
    chk(q, 32'h10005);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, 12'h018, 32'h0);
    chk(q, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
